// ===== odi_input_detect.v
// Request pin input detection with control/status register behind an AXI4-Lite slave
//
// Behaviour
// - One sticky flag per request pin, bits 15..12 for pins 3..0.
// - Each pin has its own two-bit mode field, pin3 7:6 down to pin0 1:0.
// - Flag clears only by writing 0 after reading it as 1.
// - Bits 11..9 are reserved, read as zero; software writes zero.
// - Enable bit 8 raises interrupt while any pin flag is set.
// - Mode 00 accepts a request on a falling pin edge.
// - Mode 01 samples at clock/8; sixteen consecutive low samples accept.
// - Mode 10 samples at clock/16, mode 11 at clock/128, same test.
// - Control/status register is 16 bits, readable and writable.
// - An accepted request forces the high-current pins to high impedance.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`include "odi_regs.vh"

// ----------------------------------------------------------------
// Per-pin detector
// ----------------------------------------------------------------
module odi_pin_det (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Pin and mode
    input wire pin_b_i,
    input wire [1:0] mode_i,
    // Sample enables
    input wire en8_i,
    input wire en16_i,
    input wire en128_i,
    // Result
    output wire det_o
);
    reg prev_q;
    reg [4:0] low_cnt_q;
    reg [4:0] low_cnt_d;
    reg sample_en;

    always @* begin
        case (mode_i)
            `ODI_MODE_DIV8: sample_en = en8_i;
            `ODI_MODE_DIV16: sample_en = en16_i;
            `ODI_MODE_DIV128: sample_en = en128_i;
            default: sample_en = 1'b0;
        endcase
    end

    // High samples restart the run; the count saturates so a held low stays accepted
    always @* begin
        low_cnt_d = low_cnt_q;
        if (mode_i == `ODI_MODE_EDGE) begin
            low_cnt_d = 5'h00;
        end else if (sample_en) begin
            if (pin_b_i) begin
                low_cnt_d = 5'h00;
            end else if (low_cnt_q != `ODI_LOW_SAMPLES) begin
                low_cnt_d = low_cnt_q + 5'h01;
            end
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_q <= 1'b1;
            low_cnt_q <= 5'h00;
        end else begin
            prev_q <= pin_b_i;
            low_cnt_q <= low_cnt_d;
        end
    end

    assign det_o = (mode_i == `ODI_MODE_EDGE) ? (prev_q & ~pin_b_i) :
                   (low_cnt_q == `ODI_LOW_SAMPLES);
endmodule // odi_pin_det

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module odi_input_detect (
    // Clock and reset
    input wire REF_CLK_I,
    input wire RST_B_I,
    // Request pins, active low
    input wire [3:0] HIZ_REQ_PINS_B_I,
    // Results
    output wire HIZ_REQ_O,
    output wire IRQ_O,
    // AXI4-Lite write address
    input wire S_AXI_AWVALID_I,
    output wire S_AXI_AWREADY_O,
    input wire [7:0] S_AXI_AWADDR_I,
    input wire [2:0] S_AXI_AWPROT_I,
    // AXI4-Lite write data
    input wire S_AXI_WVALID_I,
    output wire S_AXI_WREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    // AXI4-Lite write response
    output wire S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    output wire [1:0] S_AXI_BRESP_O,
    // AXI4-Lite read address
    input wire S_AXI_ARVALID_I,
    output wire S_AXI_ARREADY_O,
    input wire [7:0] S_AXI_ARADDR_I,
    input wire [2:0] S_AXI_ARPROT_I,
    // AXI4-Lite read data
    output wire S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    output wire [31:0] S_AXI_RDATA_O,
    output wire [1:0] S_AXI_RRESP_O
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [6:0] div_cnt_q;
    reg [3:0] req_flag_q;
    reg [3:0] req_flag_d;
    reg [3:0] armed_q;
    reg [3:0] armed_d;
    reg request_irq_enable_q;
    reg [7:0] req_mode_q;
    reg [3:0] evt_q;
    reg [3:0] evt_d;
    reg [3:0] evt_en_q;
    reg irq_q;
    reg hiz_q;
    reg aw_hold_q;
    reg [7:0] awaddr_q;
    reg w_hold_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    reg [31:0] rd_mux;
    reg rd_ok;

    wire [3:0] det;
    wire en8 = (div_cnt_q & `ODI_DIV8_MASK) == `ODI_DIV8_MASK;
    wire en16 = (div_cnt_q & `ODI_DIV16_MASK) == `ODI_DIV16_MASK;
    wire en128 = (div_cnt_q & `ODI_DIV128_MASK) == `ODI_DIV128_MASK;

    // ----------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------
    wire aw_take = S_AXI_AWVALID_I & ~aw_hold_q & ~bvalid_q;
    wire w_take = S_AXI_WVALID_I & ~w_hold_q & ~bvalid_q;
    wire do_wr = aw_hold_q & w_hold_q;
    wire ar_take = S_AXI_ARVALID_I & ~rvalid_q;
    wire wr_ctrl = do_wr & (awaddr_q == `ODI_OFS_CTRL_STATUS);
    wire wr_en = do_wr & (awaddr_q == `ODI_OFS_EVT_ENABLE) & wstrb_q[0];
    wire wr_clr = do_wr & (awaddr_q == `ODI_OFS_EVT_CLEAR) & wstrb_q[0];
    wire wr_ok = (awaddr_q == `ODI_OFS_CTRL_STATUS) | (awaddr_q == `ODI_OFS_EVT_STATUS) |
                 (awaddr_q == `ODI_OFS_EVT_ENABLE) | (awaddr_q == `ODI_OFS_EVT_CLEAR);
    wire rd_ctrl = ar_take & (S_AXI_ARADDR_I == `ODI_OFS_CTRL_STATUS);

    assign S_AXI_AWREADY_O = ~aw_hold_q & ~bvalid_q;
    assign S_AXI_WREADY_O = ~w_hold_q & ~bvalid_q;
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign S_AXI_ARREADY_O = ~rvalid_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RDATA_O = rdata_q;
    assign S_AXI_RRESP_O = rresp_q;
    assign HIZ_REQ_O = hiz_q;
    assign IRQ_O = irq_q;

    // ----------------------------------------------------------------
    // Detectors
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            odi_pin_det u_det (
                .clk_i(REF_CLK_I),
                .rst_b_i(RST_B_I),
                .pin_b_i(HIZ_REQ_PINS_B_I[gi]),
                .mode_i(req_mode_q[2*gi+1:2*gi]),
                .en8_i(en8),
                .en16_i(en16),
                .en128_i(en128),
                .det_o(det[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Flags, arming and events
    // ----------------------------------------------------------------
    // A flag is armed when a read returns it as 1; any later write of byte 1
    // disarms, so a stale read cannot clear a flag set again afterwards.
    always @* begin
        armed_d = armed_q;
        if (rd_ctrl) begin
            armed_d = armed_q | req_flag_q;
        end
        if (wr_ctrl & wstrb_q[1]) begin
            armed_d = 4'h0;
        end
        req_flag_d = req_flag_q;
        if (wr_ctrl & wstrb_q[1]) begin
            // Ones written are ignored; only armed zeros clear
            req_flag_d = req_flag_q & ~(armed_q & ~wdata_q[`ODI_FLAG_MSB:`ODI_FLAG_LSB]);
        end
        req_flag_d = req_flag_d | det;
        evt_d = evt_q;
        if (wr_clr) begin
            evt_d = evt_q & ~wdata_q[3:0];
        end
        evt_d = evt_d | (det & ~req_flag_q);
    end

    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_cnt_q <= 7'h00;
            req_flag_q <= `ODI_RST_FLAGS;
            armed_q <= 4'h0;
            request_irq_enable_q <= `ODI_RST_IRQ_EN;
            req_mode_q <= `ODI_RST_MODES;
            evt_q <= `ODI_RST_EVT;
            evt_en_q <= `ODI_RST_EVT;
            irq_q <= 1'b0;
            hiz_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_q + 7'h01;
            req_flag_q <= req_flag_d;
            armed_q <= armed_d;
            evt_q <= evt_d;
            if (wr_ctrl & wstrb_q[0]) begin
                req_mode_q <= wdata_q[`ODI_MODE_MSB:`ODI_MODE_LSB];
            end
            if (wr_ctrl & wstrb_q[1]) begin
                request_irq_enable_q <= wdata_q[`ODI_IRQ_EN_BIT];
            end
            if (wr_en) begin
                evt_en_q <= wdata_q[3:0];
            end
            irq_q <= (request_irq_enable_q & (|req_flag_q)) | (|(evt_q & evt_en_q));
            hiz_q <= |req_flag_q;
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always @* begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        case (S_AXI_ARADDR_I)
            `ODI_OFS_CTRL_STATUS: begin
                rd_mux[`ODI_FLAG_MSB:`ODI_FLAG_LSB] = req_flag_q;
                rd_mux[`ODI_RSVD_MSB:`ODI_RSVD_LSB] = 3'h0;
                rd_mux[`ODI_IRQ_EN_BIT] = request_irq_enable_q;
                rd_mux[`ODI_MODE_MSB:`ODI_MODE_LSB] = req_mode_q;
            end
            `ODI_OFS_EVT_STATUS: rd_mux[3:0] = evt_q;
            `ODI_OFS_EVT_ENABLE: rd_mux[3:0] = evt_en_q;
            `ODI_OFS_EVT_CLEAR: rd_mux = 32'h00000000;
            default: rd_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_hold_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `ODI_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `ODI_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR_I;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `ODI_RESP_OKAY : `ODI_RESP_SLVERR;
            end else if (bvalid_q & S_AXI_BREADY_I) begin
                bvalid_q <= 1'b0;
            end
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_ok ? `ODI_RESP_OKAY : `ODI_RESP_SLVERR;
            end else if (rvalid_q & S_AXI_RREADY_I) begin
                rvalid_q <= 1'b0;
            end
        end
    end
endmodule // odi_input_detect

// ===== odi_regs.vh
// Register map, field layout, reset values and divider counts of the input detect block
`ifndef ODI_REGS_VH
`define ODI_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ODI_OFS_CTRL_STATUS 8'h00
`define ODI_OFS_EVT_STATUS 8'h04
`define ODI_OFS_EVT_ENABLE 8'h08
`define ODI_OFS_EVT_CLEAR 8'h0C

// ----------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------
`define ODI_FLAG_LSB 12
`define ODI_FLAG_MSB 15
`define ODI_RSVD_LSB 9
`define ODI_RSVD_MSB 11
`define ODI_IRQ_EN_BIT 8
`define ODI_MODE_MSB 7
`define ODI_MODE_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ODI_RST_FLAGS 4'h0
`define ODI_RST_IRQ_EN 1'h0
`define ODI_RST_MODES 8'h00
`define ODI_RST_EVT 4'h0

// ----------------------------------------------------------------
// Detection modes and sampling
// ----------------------------------------------------------------
`define ODI_MODE_EDGE 2'h0
`define ODI_MODE_DIV8 2'h1
`define ODI_MODE_DIV16 2'h2
`define ODI_MODE_DIV128 2'h3
`define ODI_DIV8_MASK 7'h07
`define ODI_DIV16_MASK 7'h0F
`define ODI_DIV128_MASK 7'h7F
`define ODI_LOW_SAMPLES 5'h10

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define ODI_RESP_OKAY 2'h0
`define ODI_RESP_SLVERR 2'h2

`endif

// ===== odi_chk_assertions.sv
// Port-level assertions of the request input detect block
module odi_chk (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    // Pins and results
    input wire logic [3:0] HIZ_REQ_PINS_B_I,
    input wire logic HIZ_REQ_O,
    input wire logic IRQ_O,
    // Bus
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [31:0] S_AXI_RDATA_O
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge REF_CLK_I); endclocking
default disable iff (!RST_B_I);
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
property p_hiz_cause;
    $rose(HIZ_REQ_O) |-> $past(HIZ_REQ_PINS_B_I, 2) != 4'hF;
endproperty
a_hiz_cause: assert property (p_hiz_cause) else $error("hiz without low pin");
// Flags only drop through a register write
property p_hiz_clear;
    $fell(HIZ_REQ_O) |-> $past(S_AXI_BVALID_O);
endproperty
a_hiz_clear: assert property (p_hiz_clear) else $error("flag lost without write");
property p_irq_cause;
    $rose(IRQ_O) |-> HIZ_REQ_O;
endproperty
a_irq_cause: assert property (p_irq_cause) else $error("irq without flag");
property p_r_lat;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
endproperty
a_r_lat: assert property (p_r_lat) else $error("read answer late");
property p_r_busy;
    S_AXI_RVALID_O |-> !S_AXI_ARREADY_O;
endproperty
a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
property p_rsvd;
    S_AXI_RVALID_O |-> (S_AXI_RDATA_O & 32'hFFFF0E00) == 32'h00000000;
endproperty
a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
property p_r_once;
    S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O;
endproperty
a_r_once: assert property (p_r_once) else $error("read answer repeated");
property p_b_once;
    S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O;
endproperty
a_b_once: assert property (p_b_once) else $error("write answer repeated");
endmodule // odi_chk

bind odi_input_detect odi_chk chk_u (.REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I),
    .HIZ_REQ_PINS_B_I(HIZ_REQ_PINS_B_I), .HIZ_REQ_O(HIZ_REQ_O), .IRQ_O(IRQ_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .S_AXI_RDATA_O(S_AXI_RDATA_O));

// ===== odi_req_src.sv
// Model of the fault sources that pull the request pins low
module odi_req_src (
    // Clock
    input wire logic clk_i,
    // Request pins, idle high by pull-up
    output logic [3:0] pins_b_o
);
timeunit 1ns;
timeprecision 1ns;
initial pins_b_o = 4'hF;
// Level stays until the next call, as a real fault line would
task automatic drive(input int idx, input logic lvl);
    @(posedge clk_i);
    pins_b_o[idx] <= lvl;
endtask
endmodule // odi_req_src

// ===== testbench.sv
// Self-checking bench of the request input detect block
module testbench;
timeunit 1ns;
timeprecision 1ns;
logic clk = 1'b0;
logic rst_b = 1'b0;
logic [3:0] pins_b;
logic hiz, irq, awrdy, wrdy, bv, arrdy, rv;
logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
logic [7:0] awaddr = 8'h00, araddr = 8'h00;
logic [31:0] wdata = 32'h0, rdata;
logic [1:0] bresp, rresp;
int n_errors = 0, n_checks = 0;
always #5 clk = ~clk;
odi_input_detect dut_u (.REF_CLK_I(clk), .RST_B_I(rst_b), .HIZ_REQ_PINS_B_I(pins_b),
    .HIZ_REQ_O(hiz), .IRQ_O(irq), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arrdy), .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(3'h0),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp));
odi_req_src src_u (.clk_i(clk), .pins_b_o(pins_b));
// ----------------------------------------------------------------
// Bus and check tasks
// ----------------------------------------------------------------
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
        n_errors++;
        $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
endtask
task automatic results;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
endtask
task automatic tmo(input int i);
    if (i >= 40) begin
        n_errors++;
        $display("unexpected at %0t: bus timeout", $time);
        results();
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
        @(posedge clk);
        if (awv && awrdy) awv <= 1'b0;
        if (wv && wrdy) wv <= 1'b0;
        if (bv) break;
    end
    tmo(i);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, r});
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int i;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
        @(posedge clk);
        if (arv && arrdy) arv <= 1'b0;
        if (rv) break;
    end
    tmo(i);
    rready <= 1'b0;
    check(rdata, e);
    check({30'h0, rresp}, {30'h0, r});
endtask
task automatic pulse0;
    src_u.drive(0, 1'b0);
    repeat (3) @(posedge clk);
    src_u.drive(0, 1'b1);
    repeat (3) @(posedge clk);
endtask
// Short of 16 samples must not set the flag, a full run must
task automatic level(input int p, input int div);
    logic [31:0] f;
    f = ((32'h1 << p) - 32'h1) << 12;
    src_u.drive(p, 1'b0);
    repeat (14 * div) @(posedge clk);
    rd(8'h00, 32'h00E4 | f, 2'h0);
    repeat (4 * div) @(posedge clk);
    src_u.drive(p, 1'b1);
    // One more sample period lets the high level restart the saturated run count,
    // otherwise a later clear of this flag would be overridden by a stale detection
    repeat (div) @(posedge clk);
    rd(8'h00, 32'h00E4 | f | (32'h1000 << p), 2'h0);
endtask
initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'hFFFF, 2'h2);
    check({30'h0, hiz, irq}, 32'h0);
    // Reserved bits are written as zero, as software must
    wr(8'h00, 32'hF0E4, 2'h0);
    rd(8'h00, 32'h00E4, 2'h0);
    $display("test reset and layout done");
    pulse0();
    check({31'h0, hiz}, 32'h1);
    rd(8'h00, 32'h10E4, 2'h0);
    level(1, 8);
    level(2, 16);
    level(3, 128);
    $display("test detection modes done");
    check({31'h0, irq}, 32'h0);
    wr(8'h00, 32'hF1E4, 2'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(8'h00, 32'h01E4, 2'h0);
    rd(8'h00, 32'hF1E4, 2'h0);
    wr(8'h00, 32'hE1E4, 2'h0);
    rd(8'h00, 32'hE1E4, 2'h0);
    wr(8'h00, 32'h01E4, 2'h0);
    repeat (2) @(posedge clk);
    check({30'h0, hiz, irq}, 32'h0);
    $display("test flag clear done");
    wr(8'h00, 32'h00E4, 2'h0);
    wr(8'h0C, 32'hF, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    pulse0();
    check({30'h0, hiz, irq}, 32'h3);
    rd(8'h04, 32'h1, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(8'h0C, 32'h1, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h0C, 32'h0, 2'h0);
    $display("test event interrupt done");
    results();
end
endmodule // testbench
